// File: subsystem_reset_consts.vh
`ifndef SUBSYSTEM_RESET_CONSTS_VH
`define SUBSYSTEM_RESET_CONSTS_VH

// Number of controlled peripherals and register field layout.
`define PERIPH_COUNT 25
`define USB_CONTROLLER_BIT 24
`define FIELD_MASK 32'h01FF_FFFF

// Register byte offsets within the block.
`define OFFSET_RESET_CONTROL 12'h000
`define OFFSET_WATCHDOG_SELECT 12'h004
`define OFFSET_RESET_STATUS 12'h008

// Register reset values.
`define RESET_CONTROL_INIT 25'h1FF_FFFF
`define WATCHDOG_SELECT_INIT 25'h000_0000
`define RESET_STATUS_INIT 25'h000_0000

// Default chain of dependencies: no peripheral waits on another.
`define SEQUENCE_CHAIN_INIT 25'h000_0000

// Depth of the done-input synchroniser.
`define SYNC_STAGES 3

// AHB-Lite transfer and response codes.
`define HTRANS_NONSEQ_BIT 1
`define HRESP_OKAY 1'b0

`endif

// File: done_input_sync.v
`include "subsystem_reset_consts.vh"

// Brings asynchronous done levels into the bus clock domain.
module done_input_sync #(
    parameter WIDTH = `PERIPH_COUNT
) (
    input wire ref_clk,
    input wire reset_n,
    input wire [WIDTH-1:0] async_in,
    output reg [WIDTH-1:0] sync_out
);

    reg [WIDTH-1:0] stage_one;
    reg [WIDTH-1:0] stage_two;
    reg [WIDTH-1:0] stage_three;
    integer i;

    ////////////////////////////////////////////////////////////////////////
    // Three flops; a bit only changes once the second and third agree,
    // which filters a single-cycle glitch past the metastable stage.
    always @(posedge ref_clk)
    begin
        if (!reset_n)
        begin
            stage_one <= {WIDTH{1'b0}};
            stage_two <= {WIDTH{1'b0}};
            stage_three <= {WIDTH{1'b0}};
            sync_out <= {WIDTH{1'b0}};
        end
        else
        begin
            stage_one <= async_in;
            stage_two <= stage_one;
            stage_three <= stage_two;
            for (i = 0; i < WIDTH; i = i + 1)
            begin
                if (stage_two[i] == stage_three[i])
                begin
                    sync_out[i] <= stage_three[i];
                end
            end
        end
    end

endmodule

// File: subsystem_reset_controller.v
`include "subsystem_reset_consts.vh"

module subsystem_reset_controller #(
    parameter ADDR_WIDTH = 12,
    parameter NUM_PERIPH = `PERIPH_COUNT,
    parameter [`PERIPH_COUNT-1:0] SEQUENCE_CHAIN = `SEQUENCE_CHAIN_INIT
) (
    input wire ref_clk,
    input wire reset_n,
    input wire hsel,
    input wire [ADDR_WIDTH-1:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg hreadyout,
    output reg hresp,
    output reg [31:0] hrdata,
    input wire watchdog_fire,
    input wire [NUM_PERIPH-1:0] periph_done,
    output reg [NUM_PERIPH-1:0] periph_reset
);

    reg [NUM_PERIPH-1:0] reset_control;
    reg [NUM_PERIPH-1:0] watchdog_select;
    reg [NUM_PERIPH-1:0] reset_status;
    reg [NUM_PERIPH-1:0] next_reset_control;
    reg [NUM_PERIPH-1:0] next_periph_reset;
    reg [NUM_PERIPH-1:0] chain_hold;
    wire [NUM_PERIPH-1:0] done_sync;
    reg wr_pending;
    reg rd_pending;
    reg [ADDR_WIDTH-1:0] data_addr;
    wire addr_phase;
    integer k;

    // Word-aligned compare of the captured address against an offset.
    function hit;
        input [ADDR_WIDTH-1:0] addr;
        input [11:0] offset;
        begin
            hit = (addr[ADDR_WIDTH-1:2] == offset[ADDR_WIDTH-1:2]);
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Done levels come from peripherals that may run on other clocks.
    done_input_sync #(
        .WIDTH(NUM_PERIPH)
    ) u_done_sync (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .async_in(periph_done),
        .sync_out(done_sync)
    );

    // A transfer is taken when selected, NONSEQ or SEQ, and the bus is ready.
    assign addr_phase = hsel & htrans[`HTRANS_NONSEQ_BIT] & hready;

    ////////////////////////////////////////////////////////////////////////
    // Control vector update: a software write lands first, then the
    // watchdog sets selected bits so a coincident clear cannot lose it.
    always @*
    begin
        next_reset_control = reset_control;
        if (wr_pending && hit(data_addr, `OFFSET_RESET_CONTROL))
        begin
            next_reset_control = hwdata[NUM_PERIPH-1:0];
        end
        if (watchdog_fire)
        begin
            next_reset_control = next_reset_control | watchdog_select;
        end
    end

    // Dependency chain: a peripheral whose predecessor is not done stays
    // in reset, so resetting one block ripples down the sequence.
    always @*
    begin
        chain_hold = {NUM_PERIPH{1'b0}};
        for (k = 1; k < NUM_PERIPH; k = k + 1)
        begin
            chain_hold[k] = SEQUENCE_CHAIN[k] & ~done_sync[k-1];
        end
        next_periph_reset = next_reset_control | chain_hold;
    end

    ////////////////////////////////////////////////////////////////////////
    // Registers and peripheral resets. Reset values assert every
    // peripheral reset, matching a cold power-up.
    always @(posedge ref_clk)
    begin
        if (!reset_n)
        begin
            reset_control <= `RESET_CONTROL_INIT;
            watchdog_select <= `WATCHDOG_SELECT_INIT;
            reset_status <= `RESET_STATUS_INIT;
            periph_reset <= `RESET_CONTROL_INIT;
        end
        else
        begin
            reset_control <= next_reset_control;
            periph_reset <= next_periph_reset;
            if (wr_pending && hit(data_addr, `OFFSET_WATCHDOG_SELECT))
            begin
                watchdog_select <= hwdata[NUM_PERIPH-1:0];
            end
            // A block in reset reports done for at most the first cycle of
            // its reset, even if its done line lags the reset.
            reset_status <= done_sync & ~periph_reset;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // AHB-Lite slave. Writes take no wait state. Reads take one wait
    // state so the read sees a write from the preceding data phase.
    always @(posedge ref_clk)
    begin
        if (!reset_n)
        begin
            hreadyout <= 1'b1;
            hresp <= `HRESP_OKAY;
            hrdata <= 32'h0000_0000;
            wr_pending <= 1'b0;
            rd_pending <= 1'b0;
            data_addr <= {ADDR_WIDTH{1'b0}};
        end
        else
        begin
            hresp <= `HRESP_OKAY;
            if (rd_pending)
            begin
                rd_pending <= 1'b0;
                hreadyout <= 1'b1;
                hrdata <= 32'h0000_0000;
                // Reserved bits 31:25 and unmapped words read as zero.
                if (hit(data_addr, `OFFSET_RESET_CONTROL))
                begin
                    hrdata[NUM_PERIPH-1:0] <= reset_control;
                end
                else if (hit(data_addr, `OFFSET_WATCHDOG_SELECT))
                begin
                    hrdata[NUM_PERIPH-1:0] <= watchdog_select;
                end
                else if (hit(data_addr, `OFFSET_RESET_STATUS))
                begin
                    hrdata[NUM_PERIPH-1:0] <= reset_status;
                end
            end
            else
            begin
                wr_pending <= addr_phase & hwrite;
                if (addr_phase)
                begin
                    data_addr <= haddr;
                end
                if (addr_phase && !hwrite)
                begin
                    rd_pending <= 1'b1;
                    hreadyout <= 1'b0;
                end
            end
        end
    end

endmodule

// File: subsystem_reset_controller_sva.sv
module subsystem_reset_checker #(
    parameter NUM_PERIPH = 25
) (
    input wire ref_clk,
    input wire reset_n,
    input wire hsel,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire hready,
    input wire hreadyout,
    input wire hresp,
    input wire [31:0] hrdata,
    input wire watchdog_fire,
    input wire [NUM_PERIPH-1:0] periph_reset
);
// A transfer is taken only with select, a real transfer and ready all high.
wire rd_take = hsel && htrans[1] && hready && !hwrite;
wire wr_take = hsel && htrans[1] && hready && hwrite;
default clocking @(posedge ref_clk);
endclocking
default disable iff (!reset_n);
a_reset_held: assert property ($rose(reset_n) |-> &periph_reset)
    else $error("outputs not all held after reset");
a_resp_okay: assert property (hresp == 1'b0)
    else $error("response not okay");
a_read_wait: assert property (rd_take |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
a_write_fast: assert property (wr_take |=> hreadyout)
    else $error("write stalled");
a_wait_single: assert property (!hreadyout |=> hreadyout)
    else $error("wait state too long");
a_rsv_zero: assert property ($rose(hreadyout) |-> hrdata[31:25] == 7'h00)
    else $error("reserved read bits set");
// Only a software write may release a peripheral; a fall needs one.
a_release_cause: assert property (|($past(periph_reset) & ~periph_reset)
    |-> $past(wr_take, 2)) else $error("release without write");
a_raise_cause: assert property (|(periph_reset & ~$past(periph_reset))
    |-> $past(watchdog_fire) || $past(wr_take, 2))
    else $error("reset raised without cause");
endmodule
////////////////////////////////////////////////////////////////////////////////
bind subsystem_reset_controller subsystem_reset_checker #(
    .NUM_PERIPH(NUM_PERIPH)) chk_u (.ref_clk(ref_clk), .reset_n(reset_n),
    .hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .watchdog_fire(watchdog_fire), .periph_reset(periph_reset));

// File: periph_model.sv
module periph_model (
    input wire ref_clk,
    input wire [24:0] periph_reset,
    output wire [24:0] periph_done
);
timeunit 1ns;
timeprecision 1ps;
logic [24:0] stage = 25'h000_0000;
// Setup takes one quiet cycle; done drops at once when reset returns.
always @(posedge ref_clk)
begin
    stage <= ~periph_reset;
end
assign periph_done = stage & ~periph_reset;
endmodule

// File: subsystem_reset_controller_tb.sv
`include "subsystem_reset_consts.vh"
module subsystem_reset_controller_tb;
timeunit 1ns;
timeprecision 1ps;
logic ref_clk = 1'b0;
logic reset_n = 1'b0;
logic hsel = 1'b0;
logic [11:0] haddr = 12'h000;
logic [1:0] htrans = 2'b00;
logic hwrite = 1'b0;
logic [31:0] hwdata = 32'h0000_0000;
logic watchdog_fire = 1'b0;
logic [31:0] q;
wire hreadyout, hresp;
wire [31:0] hrdata;
wire [24:0] periph_done, periph_reset;
int fails = 0;
int check_count = 0;
subsystem_reset_controller dut_u (.ref_clk(ref_clk), .reset_n(reset_n),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .watchdog_fire(watchdog_fire), .periph_done(periph_done),
    .periph_reset(periph_reset));
periph_model far_u (.ref_clk(ref_clk), .periph_reset(periph_reset),
    .periph_done(periph_done));
// Free-running clock at 125 MHz.
initial
begin
    forever #4 ref_clk = ~ref_clk;
end
////////////////////////////////////////////////////////////////////////////////
// One single bus transfer; holds each phase until ready is seen high.
task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'b10;
    hwrite <= w;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    q = hrdata;
endtask
task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    check_count++;
    if (s !== e)
    begin
        fails++;
        $display("wrong value %s expected %h seen %h", n, e, s);
    end
endtask
task automatic rd(input logic [11:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0000_0000);
    chk("register", e, q);
    chk("hresp", 32'h0000_0000, {31'h0, hresp});
endtask
task automatic out(input logic [31:0] e);
    chk("periph_reset", e, {7'h00, periph_reset});
endtask
////////////////////////////////////////////////////////////////////////////////
// Reset values, with an unmapped place that must read zero.
task automatic t_reset_vals;
    rd(`OFFSET_RESET_CONTROL, `FIELD_MASK);
    rd(`OFFSET_WATCHDOG_SELECT, 32'h0000_0000);
    rd(`OFFSET_RESET_STATUS, 32'h0000_0000);
    rd(12'h00C, 32'h0000_0000);
    out(`FIELD_MASK);
endtask
// Release everything, poke read-only and reserved places, poll for done.
task automatic t_release;
    bus(1'b1, `OFFSET_RESET_CONTROL, 32'hFE00_0000);
    bus(1'b1, `OFFSET_RESET_STATUS, 32'h0000_0000);
    bus(1'b1, 12'h010, 32'hFFFF_FFFF);
    rd(`OFFSET_RESET_CONTROL, 32'h0000_0000);
    out(32'h0000_0000);
    repeat (20)
    begin
        bus(1'b0, `OFFSET_RESET_STATUS, 32'h0000_0000);
    end
    rd(`OFFSET_RESET_STATUS, `FIELD_MASK);
endtask
// The watchdog hits only the selected lowest and usb peripherals.
task automatic t_watchdog;
    bus(1'b1, `OFFSET_WATCHDOG_SELECT, 32'h0100_0001);
    rd(`OFFSET_WATCHDOG_SELECT, 32'h0100_0001);
    watchdog_fire <= 1'b1;
    @(posedge ref_clk);
    watchdog_fire <= 1'b0;
    @(posedge ref_clk);
    out(32'h0100_0001);
    rd(`OFFSET_RESET_CONTROL, 32'h0100_0001);
    rd(`OFFSET_RESET_STATUS, 32'h00FF_FFFE);
endtask
// A second reset in mid-run must restore every reset value.
task automatic t_midreset;
    reset_n <= 1'b0;
    repeat (3) @(posedge ref_clk);
    reset_n <= 1'b1;
    @(posedge ref_clk);
    out(`FIELD_MASK);
    rd(`OFFSET_WATCHDOG_SELECT, 32'h0000_0000);
    rd(`OFFSET_RESET_CONTROL, `FIELD_MASK);
    rd(`OFFSET_RESET_STATUS, 32'h0000_0000);
endtask
task automatic stop_test;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
        $display("All tests passed");
    else
        $display("Some tests failed");
    $finish;
endtask
// Main sequence after three cycles of reset; the watchdog cuts a hang.
initial
begin
    repeat (3) @(posedge ref_clk);
    reset_n <= 1'b1;
    @(posedge ref_clk);
    t_reset_vals();
    t_release();
    t_watchdog();
    t_midreset();
    stop_test();
end
initial
begin
    #10000;
    fails++;
    stop_test();
end
endmodule
